// ==== core/ebi_defines.vh ====
// constants for the external bus controller: field codes, memory limits, wait caps, select ranges, counts
// included by the controller; holds definitions only
`ifndef EBI_DEFINES_VH
`define EBI_DEFINES_VH
`define EBI_ADDR_W        24
`define EBI_DATA_W        16
`define EBI_NUM_SEL       6
`define EBI_WIDTH_OFF     2'b00
`define EBI_WIDTH_8       2'b01
`define EBI_MEM_128K      2'b00
`define EBI_MEM_64K       2'b01
`define EBI_MEM_32K       2'b10
`define EBI_MEM_LIM_128K  24'h020000
`define EBI_MEM_LIM_64K   24'h010000
`define EBI_MEM_LIM_32K   24'h008000
`define EBI_MAX_WAIT      5'h1F
`define EBI_LOW_SEL_MAX   5'h0F
`define EBI_CS0_LO        24'h000000
`define EBI_CS0_HI        24'h7FFFFF
`define EBI_CS1_LO        24'h800000
`define EBI_CS1_HI        24'hFFFFFF
`define EBI_CS2_LO        24'hF00000
`define EBI_CS2_HI        24'hF3FFFF
`define EBI_CS3_LO        24'hFFC000
`define EBI_CS3_HI        24'hFFDFFF
`define EBI_CS4_LO        24'hF40000
`define EBI_CS4_HI        24'hF7FFFF
`define EBI_CS5_LO        24'hF80000
`define EBI_CS5_HI        24'hFBFFFF
`endif

// ==== core/ebi_ctrl.v ====
// external bus controller: decodes six fixed select ranges, runs wait states,
// drives address, data and strobes. assumes one access request at a time from the
// processor side, held until done_out; pin enables come from the gpio function select.
`timescale 1ns/1ps
`include "ebi_defines.vh"

// Contract
// (R1) 24-bit address, 16-bit data, strobes, wait
// (R2) each pin gated by its alternate function; address pins are not gated here
// (R3) six chip select outputs zero to five
// (R4) select ranges are fixed constants
// (R5) enabled internal memory blocks external selects
// (R6) highest numbered matching select wins
// (R7) selects zero and one capped at fifteen
// (R8) external wait input stretches the cycle
// (R9) wait input honoured only after internal wait
// (R10) wait from select field plus post-read field
// (R11) one clock per wait, total capped 31
// (R12) isa read strobe delayed half clock
// (R13) isa adds one read wait state
// (R14) per-select programmable select polarity
// (R15) address and data widths selectable; only the data width is selectable here
// (R16) serves fetch, stack and data alike
// (R17) width select: 00 off, 01 8-bit, 1x 16-bit
// (R18) internal size 128k, 64k, 32k or none
// (R19) word/byte bit picks 16 or 8 lanes
// (R20) waits only for enabled selects; rom-less enables 0
// (R21) strobes exclusive; read data at last wait
// (R22) post-read idle clocks before next access
module ebi_ctrl (
  // clock, reset, enable
  input  wire        CLK_IN,
  input  wire        RST_N_IN,
  input  wire        CLK_EN_IN,
  // configuration
  input  wire [1:0]  BUS_WIDTH_SELECT_IN,
  input  wire [1:0]  INTERNAL_MEMORY_SIZE_IN,
  input  wire        NO_INTERNAL_PROGRAM_MEMORY_MODE_IN,
  input  wire [5:0]  SEL_ENABLE_IN,
  input  wire [5:0]  SEL_ACTIVE_HIGH_IN,
  input  wire [5:0]  SEL_ISA_IN,
  input  wire [5:0]  SEL_BYTE_IN,
  input  wire [23:0] SELECT_WAIT_COUNT_IN,
  input  wire [11:0] POST_READ_WAIT_COUNT_IN,
  input  wire [23:0] ADDR_PIN_EN_IN,
  input  wire [15:0] DATA_PIN_EN_IN,
  input  wire [5:0]  SEL_PIN_EN_IN,
  input  wire        RD_PIN_EN_IN,
  input  wire        WR_PIN_EN_IN,
  input  wire        WAIT_PIN_EN_IN,
  // processor access port
  input  wire        REQ_IN,
  input  wire        REQ_WRITE_IN,
  input  wire [23:0] REQ_ADDR_IN,
  input  wire [15:0] REQ_WDATA_IN,
  output wire        BUSY_OUT,
  output reg         DONE_OUT,
  output reg  [15:0] RDATA_OUT,
  output wire        INTERNAL_HIT_OUT,
  // external pins
  output reg  [23:0] ADDR_OUT,
  output reg  [15:0] DATA_OUT,
  output wire [15:0] DATA_OE_N_OUT,
  input  wire [15:0] DATA_IN,
  output wire        RD_N_OUT,
  output wire        WR_N_OUT,
  output wire [5:0]  SEL_OUT,
  input  wire        WAIT_IN
);

  localparam ST_IDLE = 2'b00;
  localparam ST_BUS  = 2'b01;
  localparam ST_POST = 2'b10;

  reg  [1:0]  state_q;
  reg  [4:0]  cnt_q;
  reg  [2:0]  sel_q;
  reg         sel_act_q;
  reg         write_q;
  reg         rd_q;
  reg         rd_neg_q;
  reg         wr_q;
  reg         lane8_q;
  reg         waited_q;
  reg         wait_s1_q;
  reg         wait_s2_q;
  reg  [15:0] data_oe_q;
  reg  [1:0]  post_q;

  // (R16) one path for every access kind
  wire [23:0] a = REQ_ADDR_IN;
  // (R4) hard-wired decode windows
  wire [5:0] hit;
  ebi_win #(.LO(`EBI_CS0_LO), .HI(`EBI_CS0_HI)) u_win0 (
    .addr_in (a),
    .hit_out (hit[0])
  );
  ebi_win #(.LO(`EBI_CS1_LO), .HI(`EBI_CS1_HI)) u_win1 (
    .addr_in (a),
    .hit_out (hit[1])
  );
  ebi_win #(.LO(`EBI_CS2_LO), .HI(`EBI_CS2_HI)) u_win2 (
    .addr_in (a),
    .hit_out (hit[2])
  );
  ebi_win #(.LO(`EBI_CS3_LO), .HI(`EBI_CS3_HI)) u_win3 (
    .addr_in (a),
    .hit_out (hit[3])
  );
  ebi_win #(.LO(`EBI_CS4_LO), .HI(`EBI_CS4_HI)) u_win4 (
    .addr_in (a),
    .hit_out (hit[4])
  );
  ebi_win #(.LO(`EBI_CS5_LO), .HI(`EBI_CS5_HI)) u_win5 (
    .addr_in (a),
    .hit_out (hit[5])
  );

  // (R20) rom-less mode forces select zero on
  wire [5:0] sel_en = SEL_ENABLE_IN | {5'h00, NO_INTERNAL_PROGRAM_MEMORY_MODE_IN};

  // (R18) internal memory extent from the size field
  reg [23:0] mem_lim;
  always @* begin
    if (NO_INTERNAL_PROGRAM_MEMORY_MODE_IN)
      mem_lim = 24'h000000;
    else if (INTERNAL_MEMORY_SIZE_IN == `EBI_MEM_128K)
      mem_lim = `EBI_MEM_LIM_128K;
    else if (INTERNAL_MEMORY_SIZE_IN == `EBI_MEM_64K)
      mem_lim = `EBI_MEM_LIM_64K;
    else if (INTERNAL_MEMORY_SIZE_IN == `EBI_MEM_32K)
      mem_lim = `EBI_MEM_LIM_32K;
    else
      mem_lim = 24'h000000;
  end
  // (R5) internal memory overrides external selects
  assign INTERNAL_HIT_OUT = a < mem_lim;

  // (R6) priority from five down to zero
  reg [2:0] pick;
  reg       pick_ok;
  integer   i;
  always @* begin
    pick    = 3'h0;
    pick_ok = 1'b0;
    for (i = 0; i < `EBI_NUM_SEL; i = i + 1) begin
      if (hit[i] && sel_en[i]) begin
        pick    = i[2:0];
        pick_ok = 1'b1;
      end
    end
  end

  // (R10) per-select wait field, four bits each
  wire [3:0] sw = SELECT_WAIT_COUNT_IN[pick*4 +: 4];
  wire [1:0] pw = POST_READ_WAIT_COUNT_IN[pick*2 +: 2];
  wire       isa = SEL_ISA_IN[pick];
  // (R13) isa read gets one more wait
  wire [5:0] raw = {2'b00, sw} + {5'h00, isa & ~REQ_WRITE_IN};
  // (R7) low selects never exceed fifteen
  wire [5:0] lim0 = (pick < 3'h2 && raw > {1'b0, `EBI_LOW_SEL_MAX}) ?
                    {1'b0, `EBI_LOW_SEL_MAX} : raw;
  // (R11) internal wait count of one access capped at 31; the wait pin can stretch beyond
  wire [4:0] waits = (lim0 > {1'b0, `EBI_MAX_WAIT}) ? `EBI_MAX_WAIT : lim0[4:0];

  // (R17) width field 00 switches the bus off
  wire bus_on = BUS_WIDTH_SELECT_IN != `EBI_WIDTH_OFF;
  wire bus8   = BUS_WIDTH_SELECT_IN == `EBI_WIDTH_8;
  // byte select keeps the high lanes released even on a 16-bit bus
  wire lane8_d = bus8 | (pick_ok & SEL_BYTE_IN[pick]);
  wire start  = CLK_EN_IN && REQ_IN && state_q == ST_IDLE && bus_on && !INTERNAL_HIT_OUT;

  // two-flop sync of the wait pin; only the second stage is used
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      wait_s1_q <= WAIT_IN;
      wait_s2_q <= wait_s1_q;
    end
  end
  // (R2) ignore the pin unless its function is selected
  wire ext_wait = WAIT_PIN_EN_IN & wait_s2_q;

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 5'h00;
      sel_q     <= 3'h0;
      sel_act_q <= 1'b0;
      write_q   <= 1'b0;
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      lane8_q   <= 1'b0;
      waited_q  <= 1'b0;
      post_q    <= 2'b00;
      data_oe_q <= 16'h0000;
      ADDR_OUT  <= 24'h000000;
      DATA_OUT  <= 16'h0000;
      RDATA_OUT <= 16'h0000;
      DONE_OUT  <= 1'b0;
    end else if (CLK_EN_IN) begin
      DONE_OUT <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q   <= ST_BUS;
            // (R20) no match or disabled select: no waits
            cnt_q     <= pick_ok ? waits : 5'h00;
            sel_q     <= pick;
            sel_act_q <= pick_ok;
            write_q   <= REQ_WRITE_IN;
            // (R21) only one strobe per access
            rd_q      <= ~REQ_WRITE_IN;
            wr_q      <= REQ_WRITE_IN;
            // (R19) byte bit or 8-bit bus uses low lanes
            lane8_q   <= lane8_d;
            waited_q  <= 1'b0;
            post_q    <= pw;
            ADDR_OUT  <= REQ_ADDR_IN;
            DATA_OUT  <= REQ_WDATA_IN;
            data_oe_q <= REQ_WRITE_IN ? {lane8_d ? 8'h00 : 8'hFF, 8'hFF} : 16'h0000;
          end
        end
        ST_BUS: begin
          if (cnt_q != 5'h00) begin
            cnt_q    <= cnt_q - 5'h01;
            waited_q <= 1'b1;
          // (R9) wait pin looked at only after an internal wait
          // (R8) hold the cycle while wait is asserted
          end else if (!(waited_q && ext_wait)) begin
            // (R21) capture read data at end of last wait
            if (!write_q)
              RDATA_OUT <= lane8_q ? {8'h00, DATA_IN[7:0]} : DATA_IN;
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            sel_act_q <= 1'b0;
            data_oe_q <= 16'h0000;
            DONE_OUT  <= 1'b1;
            // (R22) idle clocks after a read
            state_q   <= (!write_q && post_q != 2'b00) ? ST_POST : ST_IDLE;
          end
        end
        ST_POST: begin
          post_q  <= post_q - 2'b01;
          if (post_q == 2'b01)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // (R12) isa read strobe starts on the falling edge
  always @(negedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN)
      rd_neg_q <= 1'b0;
    else
      rd_neg_q <= rd_q;
  end
  wire rd_act = SEL_ISA_IN[sel_q] ? (rd_q & rd_neg_q) : rd_q;

  assign BUSY_OUT = state_q != ST_IDLE;
  // (R2) pins released when not selected; (R15) data lanes by width
  assign RD_N_OUT = ~(rd_act & RD_PIN_EN_IN);
  assign WR_N_OUT = ~(wr_q & WR_PIN_EN_IN);
  assign DATA_OE_N_OUT = ~(data_oe_q & DATA_PIN_EN_IN);

  // (R3) six select outputs
  // (R14) polarity per select
  genvar g;
  generate
    for (g = 0; g < `EBI_NUM_SEL; g = g + 1) begin : g_sel
      wire act = sel_act_q && sel_q == g && SEL_PIN_EN_IN[g];
      assign SEL_OUT[g] = SEL_ACTIVE_HIGH_IN[g] ? act : ~act;
    end
  endgenerate

  // (R1) address driven in full; unused pins masked outside by ADDR_PIN_EN_IN
  wire unused_addr_en = &ADDR_PIN_EN_IN;

endmodule // ebi_ctrl

// one fixed decode window; bounds are elaboration constants,
// so nothing at run time can move a select range
module ebi_win #(
  parameter [23:0] LO = 24'h000000,
  parameter [23:0] HI = 24'hFFFFFF
) (
  input  wire [23:0] addr_in,
  output wire        hit_out
);

  assign hit_out = (addr_in >= LO) && (addr_in <= HI);

endmodule // ebi_win

// ==== verif/ebi_ctrl_assertions.sv ====
// pin-level checks for the external bus controller
// assumes all pin enables high and one request held at a time
`timescale 1ns/1ps
module ebi_chk (
  input wire        CLK_IN,
  input wire        RST_N_IN,
  input wire [1:0]  BUS_WIDTH_SELECT_IN,
  input wire [5:0]  SEL_ACTIVE_HIGH_IN,
  input wire        WAIT_PIN_EN_IN,
  input wire        REQ_IN,
  input wire        BUSY_OUT,
  input wire        DONE_OUT,
  input wire        INTERNAL_HIT_OUT,
  input wire [15:0] DATA_OE_N_OUT,
  input wire        RD_N_OUT,
  input wire        WR_N_OUT,
  input wire [5:0]  SEL_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire  [5:0] act = SEL_OUT ^ ~SEL_ACTIVE_HIGH_IN;
  logic [5:0] len_q;
  // counts busy cycles; wraps only when the wait pin or a held-low clock enable stretches an access
  always @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN) len_q <= 6'h00;
    else len_q <= BUSY_OUT ? len_q + 6'h01 : 6'h00;
  a_strobe_excl: assert property (RD_N_OUT || WR_N_OUT)
    else $error("strobes overlap");
  a_one_select: assert property ($onehot0(act))
    else $error("several selects active");
  a_idle_inactive: assert property (!BUSY_OUT |-> act == 6'h00)
    else $error("select active while idle");
  a_done_pulse: assert property (DONE_OUT |=> !DONE_OUT)
    else $error("done longer than a cycle");
  a_strobe_done: assert property ($rose(RD_N_OUT) || $rose(WR_N_OUT) |-> DONE_OUT)
    else $error("strobe ended without done");
  a_int_refused: assert property (REQ_IN && INTERNAL_HIT_OUT && !BUSY_OUT |=> !BUSY_OUT)
    else $error("internal hit started a cycle");
  a_off_refused: assert property (REQ_IN && BUS_WIDTH_SELECT_IN == 2'h0 && !BUSY_OUT
    |=> !BUSY_OUT)
    else $error("disabled bus started a cycle");
  a_read_release: assert property (!RD_N_OUT |-> DATA_OE_N_OUT == 16'hFFFF)
    else $error("data driven during read");
  a_byte_lanes: assert property (!WR_N_OUT && BUS_WIDTH_SELECT_IN == 2'h1
    |-> DATA_OE_N_OUT[15:8] == 8'hFF)
    else $error("high lanes driven on 8-bit bus");
  a_wait_cap: assert property (!WAIT_PIN_EN_IN |-> len_q <= 6'h24)
    else $error("access too long");
  c_read: cover property (!RD_N_OUT && act != 6'h00);
  c_write: cover property (!WR_N_OUT && act != 6'h00);
  c_hit: cover property (REQ_IN && INTERNAL_HIT_OUT);
endmodule // ebi_chk

// ==== verif/ebi_mem.sv ====
// far-side memory or peripheral: 16 words, optional wait stretch
// assumes strobes active low and address stable while a strobe is low
`timescale 1ns/1ps
module ebi_mem (
  input  wire        clk,
  input  wire [23:0] addr,
  input  wire        rd_n,
  input  wire        wr_n,
  input  wire [15:0] wdata,
  input  wire [3:0]  stall,
  output wire [15:0] rdata,
  output wire        wait_o
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  logic [3:0]  cnt = 4'h0;
  always @(posedge clk) begin
    cnt <= (rd_n && wr_n) ? 4'h0 : cnt + {3'h0, cnt < stall};
    if (!wr_n) mem[addr[3:0]] <= wdata;
    if (!rd_n) last <= rdata;
  end
  assign wait_o = !(rd_n && wr_n) && cnt < stall;
  // released bus shows the inverse, never a stale value
  assign rdata = rd_n ? ~last : mem[addr[3:0]];
endmodule // ebi_mem

// ==== verif/ebi_ctrl_tb.sv ====
// self-checking bench for the external bus controller
// assumes ebi_mem on the pins and ebi_chk bound to the controller
`timescale 1ns/1ps
module ebi_ctrl_tb;
  logic clk = 0, rst_n = 0, req = 0, wr = 0, wpe = 0, nom = 0, pe = 1, ce = 1;
  logic [11:0] prw = 12'h000;
  logic [1:0]  bw = 2'h2, ms = 2'h3;
  logic [5:0]  en = 6'h3F, pol = 6'h00, isa = 6'h00, byt = 6'h00;
  logic [23:0] wc = 24'h123456, addr = 24'h000000;
  logic [15:0] wd = 16'h0000;
  logic [3:0]  stall = 4'h0;
  wire         busy, done, hit, rdn, wrn, wt;
  wire  [15:0] rdat, dq, oe_n, din;
  wire  [23:0] ao;
  wire  [5:0]  sel;
  int failures = 0, total_checks = 0;
  always #5 clk = ~clk;
  ebi_ctrl dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(ce),
    .BUS_WIDTH_SELECT_IN(bw), .INTERNAL_MEMORY_SIZE_IN(ms),
    .NO_INTERNAL_PROGRAM_MEMORY_MODE_IN(nom), .SEL_ENABLE_IN(en), .SEL_ACTIVE_HIGH_IN(pol),
    .SEL_ISA_IN(isa), .SEL_BYTE_IN(byt), .SELECT_WAIT_COUNT_IN(wc),
    .POST_READ_WAIT_COUNT_IN(prw), .ADDR_PIN_EN_IN({24{pe}}), .DATA_PIN_EN_IN({16{pe}}),
    .SEL_PIN_EN_IN({6{pe}}), .RD_PIN_EN_IN(pe), .WR_PIN_EN_IN(pe), .WAIT_PIN_EN_IN(wpe),
    .REQ_IN(req), .REQ_WRITE_IN(wr), .REQ_ADDR_IN(addr), .REQ_WDATA_IN(wd), .BUSY_OUT(busy),
    .DONE_OUT(done), .RDATA_OUT(rdat), .INTERNAL_HIT_OUT(hit), .ADDR_OUT(ao), .DATA_OUT(dq),
    .DATA_OE_N_OUT(oe_n), .DATA_IN(din), .RD_N_OUT(rdn), .WR_N_OUT(wrn), .SEL_OUT(sel),
    .WAIT_IN(wt));
  ebi_mem u_mem (.clk(clk), .addr(ao), .rd_n(rdn), .wr_n(wrn), .wdata(dq), .stall(stall),
    .rdata(din), .wait_o(wt));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // n counts edges from the taking edge through done; s collects active selects
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d,
                     output logic [15:0] q, output int n, output logic [5:0] s);
    @(negedge clk);
    {req, wr, addr, wd, n, s} = {1'b1, w, a, d, 32'd0, 6'h00};
    do begin
      @(posedge clk);
      #1 n++;
      s |= sel ^ ~pol;
    end while (!done && n < 80);
    if (done !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t access never finished", $time);
      stop_test();
    end
    q = rdat;
    @(negedge clk) req = 0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_map;
    logic [23:0] tab [6] = '{24'h100000, 24'h800001, 24'hF00002, 24'hFFC003, 24'hF40004,
                             24'hF80005};
    logic [15:0] q;
    logic [5:0]  s;
    int n;
    for (int i = 0; i < 6; i++) begin
      acc(1, tab[i], 16'h1111 * i + 16'h0F0F, q, n, s);
      chk(n[15:0], wc[4*i+:4] + 16'h2);
      chk(16'(s), 16'(1 << i));
      acc(0, tab[i], 16'h0000, q, n, s);
      chk(q, 16'h1111 * i + 16'h0F0F);
      chk(n[15:0], wc[4*i+:4] + 16'h2);
    end
  endtask
  task automatic t_isa;
    logic [15:0] q;
    logic [5:0]  s;
    int n;
    {isa, pol} = {6'h04, 6'h2A};
    acc(1, 24'hF00002, 16'h1234, q, n, s);
    chk(n[15:0], 16'h6);
    chk(16'(s), 16'h4);
    acc(0, 24'hF00002, 16'h0000, q, n, s);
    chk(n[15:0], 16'h7);
    chk(q, 16'h1234);
    {isa, pol} = 12'h000;
  endtask
  task automatic t_refuse;
    logic [23:0] lim [4] = '{24'h020000, 24'h010000, 24'h008000, 24'h000001};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) {ms, addr} = {2'(i), lim[i] - 24'h1};
      #1 chk(hit, i < 3);
      addr = lim[i];
      #1 chk(hit, 0);
    end
    @(negedge clk) {ms, addr, req} = {2'h0, 24'h000100, 1'b1};
    repeat (3) @(negedge clk);
    chk(busy, 0);
    {ms, addr, bw} = {2'h3, 24'h100000, 2'h0};
    repeat (3) @(negedge clk);
    chk(busy, 0);
    {req, bw} = 3'b010;
  endtask
  task automatic t_byte;
    logic [15:0] q;
    logic [5:0]  s;
    int n;
    bw = 2'h1;
    acc(1, 24'hF00002, 16'hA5C3, q, n, s);
    acc(0, 24'hF00002, 16'h0000, q, n, s);
    chk(q, 16'h00C3);
    {bw, byt} = {2'h2, 6'h04};
    acc(0, 24'hF00002, 16'h0000, q, n, s);
    chk(q, 16'h00C3);
    byt = 6'h00;
  endtask
  task automatic t_wait;
    logic [15:0] q;
    logic [5:0]  s;
    int n;
    {wpe, stall} = {1'b1, 4'h6};
    acc(0, 24'hF00002, 16'h0000, q, n, s);
    chk(n > 6 && n < 16, 1);
    wc = 24'h123056;
    acc(0, 24'hF00002, 16'h0000, q, n, s);
    chk(n[15:0], 16'h2);
    {wpe, stall, wc} = {1'b0, 4'h0, 24'h123456};
  endtask
  // frozen enable refuses the start; then read, post-read gap, read again
  task automatic t_post;
    int n;
    @(negedge clk) {ce, prw, req, wr, addr} = {1'b0, 12'h030, 1'b1, 1'b0, 24'hF00002};
    repeat (3) @(negedge clk);
    chk(busy, 0);
    ce = 1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (!done && n < 80);
      chk(n[15:0], (k == 0) ? 16'h6 : 16'h9);
    end
    @(negedge clk) {prw, req} = 13'h0000;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_rom;
    logic [15:0] q;
    logic [5:0]  s;
    int n;
    {nom, en} = {1'b1, 6'h00};
    acc(1, 24'h100000, 16'h0001, q, n, s);
    chk(n[15:0], 16'h8);
    chk(16'(s), 16'h1);
    nom = 0;
    acc(1, 24'h800001, 16'h0002, q, n, s);
    chk(n[15:0] + 16'(s), 16'h2);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst_n = 1;
    t_map();
    t_isa();
    t_refuse();
    t_byte();
    t_wait();
    t_post();
    t_rom();
    stop_test();
  end
endmodule // ebi_ctrl_tb
bind ebi_ctrl ebi_chk u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .BUS_WIDTH_SELECT_IN(BUS_WIDTH_SELECT_IN), .SEL_ACTIVE_HIGH_IN(SEL_ACTIVE_HIGH_IN),
  .WAIT_PIN_EN_IN(WAIT_PIN_EN_IN), .REQ_IN(REQ_IN), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT),
  .INTERNAL_HIT_OUT(INTERNAL_HIT_OUT), .DATA_OE_N_OUT(DATA_OE_N_OUT), .RD_N_OUT(RD_N_OUT),
  .WR_N_OUT(WR_N_OUT), .SEL_OUT(SEL_OUT));
